// ### hw/mpsc_master_cfg.sv
// Master-page bank: bias impedance, channel B gating, sync termination, SYSREF delay
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RQ1 - Host writes ones to bits 6,4, zeros elsewhere
// RQ2 - Bias impedance bit selects direct or high-impedance drive
// RQ3 - Channel B power-down honoured only while gate set
// RQ4 - Bit 0 one disconnects sync input termination
// RQ5 - SYSREF delay inserted only while enable bit set
// RQ6 - Delay steps of 25 ps, first 175 ps
// RQ7 - Five-bit code from two registers, high then low
// RQ8 - Code 01000 is 175 ps, each decrement adds 25
// RQ9 - Power-down bit set powers channel B down
// RQ10 - Reset clears all; selected writes update register
module mpsc_master_cfg (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        spi_sclk,
    input  wire logic        spi_sen_n,
    input  wire logic        spi_sdin,
    output logic             spi_sdout,
    output logic             spi_sdout_oe,
    input  wire logic        master_page_sel,
    input  wire logic        chan_b_powerdown,
    output logic             raise_bias_common_impedance,
    output logic             chan_b_powered_down,
    output logic             sync_input_termination_off,
    output logic             sysref_delay_enable,
    output logic [4:0]       sysref_delay_code,
    output logic [9:0]       sysref_delay_ps
);
    // Total nominal delay; codes above the first step saturate, codes below it extend the ramp
    function automatic logic [mpsc_pkg::DEL_PS_W-1:0] delay_ps_of(
        input logic [mpsc_pkg::DEL_CODE_W-1:0] code);
        int steps;
        steps = 0;
        if (code < mpsc_pkg::DEL_FIRST_CODE)
            steps = int'(mpsc_pkg::DEL_FIRST_CODE) - int'(code);
        delay_ps_of = mpsc_pkg::DEL_PS_W'(mpsc_pkg::DEL_FIRST_PS + steps * mpsc_pkg::DEL_STEP_PS);
    endfunction : delay_ps_of

    logic [mpsc_pkg::DATA_W-1:0]    cm_bias_r;
    logic [mpsc_pkg::DATA_W-1:0]    sync_term_r;
    logic [mpsc_pkg::DATA_W-1:0]    del_high_r;
    logic [mpsc_pkg::DATA_W-1:0]    del_low_r;
    logic                           imp_out_r;
    logic                           chb_pd_r;
    logic                           term_off_r;
    logic                           del_en_out_r;
    logic [4:0]                     del_code_out_r;
    logic [9:0]                     del_ps_r;
    logic [mpsc_pkg::ADDR_W-1:0]    rd_addr;
    logic [mpsc_pkg::DATA_W-1:0]    rd_data;
    logic                           wr_vld;
    mpsc_pkg::mpsc_wr_s             wr;

    mpsc_spi_slave u_spi (
        .clk          (clk),
        .rst_n        (rst_n),
        .spi_sclk     (spi_sclk),
        .spi_sen_n    (spi_sen_n),
        .spi_sdin     (spi_sdin),
        .spi_sdout    (spi_sdout),
        .spi_sdout_oe (spi_sdout_oe),
        .rd_addr      (rd_addr),
        .rd_data      (rd_data),
        .wr_vld       (wr_vld),
        .wr           (wr)
    );

    // Writes land only while the master page is selected
    wire wr_sel   = wr_vld & master_page_sel;
    wire wr_cm    = wr_sel && wr.addr == mpsc_pkg::OFS_CM_BIAS;
    wire wr_sync  = wr_sel && wr.addr == mpsc_pkg::OFS_SYNC_TERM;
    wire wr_dhigh = wr_sel && wr.addr == mpsc_pkg::OFS_DEL_HIGH;
    wire wr_dlow  = wr_sel && wr.addr == mpsc_pkg::OFS_DEL_LOW;

    // Must-write-one bits are write-only, so they are accepted but not kept
    wire [mpsc_pkg::DATA_W-1:0] cm_nxt    = wr_cm    ? (wr.data & mpsc_pkg::MASK_CM_BIAS)
                                                     : cm_bias_r;
    wire [mpsc_pkg::DATA_W-1:0] sync_nxt  = wr_sync  ? (wr.data & mpsc_pkg::MASK_SYNC_TERM)
                                                     : sync_term_r;
    wire [mpsc_pkg::DATA_W-1:0] dhigh_nxt = wr_dhigh ? (wr.data & mpsc_pkg::MASK_DEL_HIGH)
                                                     : del_high_r;
    wire [mpsc_pkg::DATA_W-1:0] dlow_nxt  = wr_dlow  ? (wr.data & mpsc_pkg::MASK_DEL_LOW)
                                                     : del_low_r;

    // Unmapped or unselected addresses read zero
    wire [mpsc_pkg::DATA_W-1:0] rd_sel =
        (rd_addr == mpsc_pkg::OFS_CM_BIAS)   ? cm_bias_r   :
        (rd_addr == mpsc_pkg::OFS_SYNC_TERM) ? sync_term_r :
        (rd_addr == mpsc_pkg::OFS_DEL_HIGH)  ? del_high_r  :
        (rd_addr == mpsc_pkg::OFS_DEL_LOW)   ? del_low_r   : mpsc_pkg::REG_RST;
    assign rd_data = master_page_sel ? rd_sel : mpsc_pkg::REG_RST;

    wire       del_en    = del_high_r[mpsc_pkg::BIT_DEL_EN];
    wire [4:0] del_code  = {del_high_r[mpsc_pkg::DEL_HI_MSB:mpsc_pkg::DEL_HI_LSB],
                            del_low_r[mpsc_pkg::DEL_LO_MSB:mpsc_pkg::DEL_LO_LSB]}; // [RQ7]
    wire       chb_gated = sync_term_r[mpsc_pkg::BIT_CHB_GATE] & chan_b_powerdown; // [RQ3] [RQ9]

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cm_bias_r   <= mpsc_pkg::REG_RST; // [RQ10]
            sync_term_r <= mpsc_pkg::REG_RST;
            del_high_r  <= mpsc_pkg::REG_RST;
            del_low_r   <= mpsc_pkg::REG_RST;
        end else begin
            cm_bias_r   <= cm_nxt; // [RQ10]
            sync_term_r <= sync_nxt;
            del_high_r  <= dhigh_nxt;
            del_low_r   <= dlow_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            imp_out_r      <= 1'b0;
            chb_pd_r       <= 1'b0;
            term_off_r     <= 1'b0;
            del_en_out_r   <= 1'b0;
            del_code_out_r <= '0;
            del_ps_r       <= mpsc_pkg::DEL_NONE_PS;
        end else begin
            imp_out_r      <= cm_bias_r[mpsc_pkg::BIT_CM_IMP]; // [RQ2]
            chb_pd_r       <= chb_gated; // [RQ3] [RQ9]
            term_off_r     <= sync_term_r[mpsc_pkg::BIT_TERM_OFF]; // [RQ4]
            del_en_out_r   <= del_en; // [RQ5]
            del_code_out_r <= del_code; // [RQ7]
            // Nothing is added to SYSREF while the delay is disabled
            del_ps_r       <= del_en ? delay_ps_of(del_code) : mpsc_pkg::DEL_NONE_PS; // [RQ5] [RQ6] [RQ8]
        end
    end

    assign raise_bias_common_impedance = imp_out_r;
    assign chan_b_powered_down         = chb_pd_r;
    assign sync_input_termination_off  = term_off_r;
    assign sysref_delay_enable         = del_en_out_r;
    assign sysref_delay_code           = del_code_out_r;
    assign sysref_delay_ps             = del_ps_r;

    sequence s_cm_write;
        wr_vld && master_page_sel && wr.addr == mpsc_pkg::OFS_CM_BIAS;
    endsequence

    sequence s_dlow_write;
        wr_vld && master_page_sel && wr.addr == mpsc_pkg::OFS_DEL_LOW;
    endsequence

    sequence s_dhigh_write;
        wr_vld && master_page_sel && wr.addr == mpsc_pkg::OFS_DEL_HIGH;
    endsequence

    a_cm_write_out: assert property (@(posedge clk) disable iff (!rst_n) // [RQ2] [RQ10]
        s_cm_write |-> ##2 raise_bias_common_impedance == $past(wr.data[mpsc_pkg::BIT_CM_IMP], 2))
        else $error("bias impedance output did not follow write");

    a_unsel_write: assert property (@(posedge clk) disable iff (!rst_n) // [RQ10]
        (wr_vld && !master_page_sel) |=> $stable(cm_bias_r) && $stable(del_low_r))
        else $error("write landed without master page selected");

    a_chb_gate_off: assert property (@(posedge clk) disable iff (!rst_n) // [RQ3]
        !sync_term_r[mpsc_pkg::BIT_CHB_GATE] |=> !chan_b_powered_down)
        else $error("channel B powered down while gate clear");

    a_chb_pd_on: assert property (@(posedge clk) disable iff (!rst_n) // [RQ9]
        (sync_term_r[mpsc_pkg::BIT_CHB_GATE] && chan_b_powerdown)[*2] |-> chan_b_powered_down)
        else $error("channel B not powered down");

    a_term_follow: assert property (@(posedge clk) disable iff (!rst_n) // [RQ4]
        (wr_vld && master_page_sel && wr.addr == mpsc_pkg::OFS_SYNC_TERM)
        |-> ##2 sync_input_termination_off == $past(wr.data[mpsc_pkg::BIT_TERM_OFF], 2))
        else $error("termination control did not follow write");

    a_del_off_zero: assert property (@(posedge clk) disable iff (!rst_n) // [RQ5]
        !sysref_delay_enable |-> sysref_delay_ps == 10'h000)
        else $error("delay present while disabled");

    a_del_first: assert property (@(posedge clk) disable iff (!rst_n) // [RQ6] [RQ8]
        (sysref_delay_enable && sysref_delay_code == 5'h08 && $stable(sysref_delay_code))
        |-> sysref_delay_ps == 10'h0AF)
        else $error("first delay step not 175 ps");

    a_del_step: assert property (@(posedge clk) disable iff (!rst_n) // [RQ6] [RQ8]
        (sysref_delay_enable && sysref_delay_code == 5'h03 && $stable(sysref_delay_code))
        |-> sysref_delay_ps == 10'h12C)
        else $error("code 00011 not 300 ps");

    a_code_join: assert property (@(posedge clk) disable iff (!rst_n) // [RQ7]
        s_dlow_write |-> ##2 sysref_delay_code[2:0] ==
            $past(wr.data[mpsc_pkg::DEL_LO_MSB:mpsc_pkg::DEL_LO_LSB], 2))
        else $error("low delay bits not from low register");

    a_reset_clear: assert property (@(posedge clk) // [RQ10]
        !rst_n |=> sysref_delay_code == 5'h00 && !chan_b_powered_down && !sysref_delay_enable)
        else $error("settings not cleared by reset");

    a_del_en_write: assert property (@(posedge clk) disable iff (!rst_n) // [RQ5]
        s_dhigh_write |-> ##2 sysref_delay_enable == $past(wr.data[mpsc_pkg::BIT_DEL_EN], 2))
        else $error("delay enable did not follow write");

    a_code_high: assert property (@(posedge clk) disable iff (!rst_n) // [RQ7]
        s_dhigh_write |-> ##2 sysref_delay_code[4:3] ==
            $past(wr.data[mpsc_pkg::DEL_HI_MSB:mpsc_pkg::DEL_HI_LSB], 2))
        else $error("high delay bits not from enable register");

    // Further points of the nominal delay ramp, then channel B, page-select and output-enable checks
    a_del_second: assert property (@(posedge clk) disable iff (!rst_n) // [RQ6] [RQ8]
        (sysref_delay_enable && sysref_delay_code == 5'h07 && $stable(sysref_delay_code))
        |-> sysref_delay_ps == 10'h0C8)
        else $error("code 00111 not 200 ps");

    a_del_mid: assert property (@(posedge clk) disable iff (!rst_n) // [RQ6] [RQ8]
        (sysref_delay_enable && sysref_delay_code == 5'h04 && $stable(sysref_delay_code))
        |-> sysref_delay_ps == 10'h113)
        else $error("code 00100 not 275 ps");

    a_chb_pd_off: assert property (@(posedge clk) disable iff (!rst_n) // [RQ9]
        (sync_term_r[mpsc_pkg::BIT_CHB_GATE] && !chan_b_powerdown) |=> !chan_b_powered_down)
        else $error("channel B down while power-down bit clear");

    a_unsel_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RQ10]
        (wr_vld && !master_page_sel) |=> $stable(sync_term_r) && $stable(del_high_r))
        else $error("write landed without master page selected");

    a_oe_release: assert property (@(posedge clk) disable iff (!rst_n) // [RQ10]
        spi_sen_n |=> !spi_sdout_oe)
        else $error("serial output still driven after frame end");
endmodule : mpsc_master_cfg
`default_nettype wire

// ### hw/mpsc_pkg.sv
// Shared constants and types for the master-page sync and SYSREF configuration bank
package mpsc_pkg;

    // Serial frame: read flag, three ignored bits, address, data
    localparam int FRAME_W      = 24;
    localparam int ADDR_W       = 12;
    localparam int DATA_W       = 8;
    localparam int FRM_RW_BIT   = 23;
    localparam int FRM_ADDR_LSB = 8;
    localparam int HDR_W        = 16;
    localparam int CNT_W        = 5;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CM_BIAS   = 12'h032;
    localparam logic [ADDR_W-1:0] OFS_SYNC_TERM = 12'h039;
    localparam logic [ADDR_W-1:0] OFS_DEL_HIGH  = 12'h03C;
    localparam logic [ADDR_W-1:0] OFS_DEL_LOW   = 12'h05A;

    localparam logic [DATA_W-1:0] REG_RST = 8'h00;

    // Field positions
    localparam int BIT_CM_IMP     = 5;
    localparam int BIT_ALWAYS1_HI = 6;
    localparam int BIT_ALWAYS1_LO = 4;
    localparam int BIT_CHB_GATE   = 1;
    localparam int BIT_TERM_OFF   = 0;
    localparam int BIT_DEL_EN     = 6;
    localparam int DEL_HI_MSB     = 1;
    localparam int DEL_HI_LSB     = 0;
    localparam int DEL_LO_MSB     = 7;
    localparam int DEL_LO_LSB     = 5;

    // Writable field masks; everything else is write-only and reads zero
    localparam logic [DATA_W-1:0] MASK_CM_BIAS   = 8'h20;
    localparam logic [DATA_W-1:0] MASK_SYNC_TERM = 8'h03;
    localparam logic [DATA_W-1:0] MASK_DEL_HIGH  = 8'h43;
    localparam logic [DATA_W-1:0] MASK_DEL_LOW   = 8'hE0;

    // Nominal SYSREF delay
    localparam int             DEL_CODE_W     = 5;
    localparam int             DEL_PS_W       = 10;
    localparam int             DEL_FIRST_PS   = 175;
    localparam int             DEL_STEP_PS    = 25;
    localparam logic [4:0]     DEL_FIRST_CODE = 5'h08;
    localparam logic [9:0]     DEL_NONE_PS    = 10'h000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mpsc_wr_s;

endpackage : mpsc_pkg

// ### hw/mpsc_spi_slave.sv
// Serial slave that turns host frames into register writes and read answers
`timescale 1ns/10ps
`default_nettype none
module mpsc_spi_slave (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         spi_sclk,
    input  wire logic                         spi_sen_n,
    input  wire logic                         spi_sdin,
    output logic                              spi_sdout,
    output logic                              spi_sdout_oe,
    output logic [mpsc_pkg::ADDR_W-1:0]       rd_addr,
    input  wire logic [mpsc_pkg::DATA_W-1:0]  rd_data,
    output logic                              wr_vld,
    output mpsc_pkg::mpsc_wr_s                wr
);
    logic                           sclk_d_r;
    logic [mpsc_pkg::CNT_W-1:0]     cnt_r;
    logic [mpsc_pkg::FRAME_W-1:0]   shift_r;
    logic [mpsc_pkg::DATA_W-1:0]    rdsh_r;
    logic                           rd_act_r;
    logic                           wr_vld_r;
    mpsc_pkg::mpsc_wr_s             wr_r;
    logic                           sdout_r;
    logic                           oe_r;

    wire                          rise     = spi_sclk & ~sclk_d_r & ~spi_sen_n;
    wire                          fall     = ~spi_sclk & sclk_d_r & ~spi_sen_n;
    wire [mpsc_pkg::FRAME_W-1:0]  word_nxt = {shift_r[mpsc_pkg::FRAME_W-2:0], spi_sdin};
    wire                          hdr_done = rise && cnt_r == mpsc_pkg::CNT_W'(mpsc_pkg::HDR_W-1);
    wire                          frm_done = rise && cnt_r == mpsc_pkg::CNT_W'(mpsc_pkg::FRAME_W-1);
    // At the header's last bit the read flag sits at the header MSB
    wire                          hdr_rd   = word_nxt[mpsc_pkg::HDR_W-1];

    assign rd_addr      = word_nxt[mpsc_pkg::ADDR_W-1:0];
    assign wr_vld       = wr_vld_r;
    assign wr           = wr_r;
    assign spi_sdout    = sdout_r;
    assign spi_sdout_oe = oe_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_d_r <= 1'b0;
            cnt_r    <= '0;
            shift_r  <= '0;
            rdsh_r   <= '0;
            rd_act_r <= 1'b0;
            wr_vld_r <= 1'b0;
            wr_r     <= '0;
            sdout_r  <= 1'b0;
            oe_r     <= 1'b0;
        end else begin
            sclk_d_r <= spi_sclk;
            wr_vld_r <= frm_done & ~word_nxt[mpsc_pkg::FRM_RW_BIT];
            if (frm_done) begin
                wr_r.addr <= word_nxt[mpsc_pkg::FRM_ADDR_LSB +: mpsc_pkg::ADDR_W];
                wr_r.data <= word_nxt[mpsc_pkg::DATA_W-1:0];
            end
            if (spi_sen_n) begin
                cnt_r    <= '0;
                rd_act_r <= 1'b0;
                oe_r     <= 1'b0;
            end else if (rise) begin
                shift_r <= word_nxt;
                cnt_r   <= cnt_r + 1'b1;
                if (hdr_done) begin
                    rd_act_r <= hdr_rd;
                    rdsh_r   <= rd_data;
                end
            end else if (fall && rd_act_r) begin
                // Data leaves on falling edges so the host can sample on rising ones
                sdout_r <= rdsh_r[mpsc_pkg::DATA_W-1];
                rdsh_r  <= {rdsh_r[mpsc_pkg::DATA_W-2:0], 1'b0};
                oe_r    <= 1'b1;
            end
        end
    end
endmodule : mpsc_spi_slave
`default_nettype wire

// ### test/mpsc_host_model.sv
// Host controller model that sends serial configuration frames
`timescale 1ns/10ps
`default_nettype none
module mpsc_host_model (
    input  wire logic clk,
    input  wire logic spi_sdout,
    input  wire logic spi_sdout_oe,
    output logic      spi_sclk,
    output logic      spi_sen_n,
    output logic      spi_sdin
);
    // Each serial phase lasts four clock cycles, four times the slave's one-cycle minimum
    localparam int HALF = 4;

    initial begin
        spi_sclk  = 1'b0;
        spi_sen_n = 1'b1;
        spi_sdin  = 1'b0;
    end

    task automatic xfer(input logic rd, input logic [11:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
        logic [23:0] frm;
        frm   = {rd, 3'h0, addr, wdata};
        rdata = 8'h00;
        @(posedge clk);
        #1 spi_sen_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_sdin = frm[i];
            repeat (HALF) @(posedge clk);
            #1;
            if (i < 8) rdata[i] = spi_sdout_oe ? spi_sdout : 1'bx;
            spi_sclk = 1'b1;
            repeat (HALF) @(posedge clk);
            #1 spi_sclk = 1'b0;
        end
        repeat (HALF) @(posedge clk);
        // A released data line must not keep its last level
        #1 spi_sen_n = 1'b1;
        spi_sdin = ~spi_sdin;
        repeat (HALF) @(posedge clk);
        // Return just past an edge so callers change inputs off the sampling edge
        #1;
    endtask : xfer
endmodule : mpsc_host_model
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the master-page sync and SYSREF configuration bank
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic       clk, rst_n, page_sel, pd_in;
    wire logic  sclk, sen_n, sdin, sdout, sdout_oe;
    wire logic  bias, pd_out, term, den;
    wire logic [4:0] dcode;
    wire logic [9:0] dps;
    int         err_count = 0;
    int         num_checks = 0;
    int         cyc = 0;

    mpsc_host_model host (.clk(clk), .spi_sdout(sdout), .spi_sdout_oe(sdout_oe),
        .spi_sclk(sclk), .spi_sen_n(sen_n), .spi_sdin(sdin));
    mpsc_master_cfg uut (.clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_sen_n(sen_n),
        .spi_sdin(sdin), .spi_sdout(sdout), .spi_sdout_oe(sdout_oe),
        .master_page_sel(page_sel), .chan_b_powerdown(pd_in),
        .raise_bias_common_impedance(bias), .chan_b_powered_down(pd_out),
        .sync_input_termination_off(term), .sysref_delay_enable(den),
        .sysref_delay_code(dcode), .sysref_delay_ps(dps));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic give_verdict;
        if (err_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] unused;
        host.xfer(1'b0, a, d, unused);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.xfer(1'b1, a, 8'h00, v);
        chk("read data", {2'h0, v}, {2'h0, exp});
    endtask : rd

    task automatic t_reset;
        chk("all outputs", {bias, pd_out, term, den, dcode, 1'b0}, 10'h000);
        chk("delay ps", dps, 10'h000);
        rd(mpsc_pkg::OFS_CM_BIAS, 8'h00);
        rd(mpsc_pkg::OFS_SYNC_TERM, 8'h00);
        rd(mpsc_pkg::OFS_DEL_HIGH, 8'h00);
        rd(mpsc_pkg::OFS_DEL_LOW, 8'h00);
    endtask : t_reset

    task automatic t_bias;
        wr(mpsc_pkg::OFS_CM_BIAS, 8'hFF);
        chk("bias impedance", {9'h0, bias}, 10'h001);
        rd(mpsc_pkg::OFS_CM_BIAS, 8'h20);
        wr(mpsc_pkg::OFS_CM_BIAS, 8'h00);
        chk("bias impedance", {9'h0, bias}, 10'h000);
    endtask : t_bias

    task automatic t_gate;
        for (int g = 0; g < 2; g++) begin
            wr(mpsc_pkg::OFS_SYNC_TERM, g ? 8'h52 : 8'h51); // Bits 6 and 4 always one
            chk("termination off", {9'h0, term}, g ? 10'h000 : 10'h001);
            for (int p = 0; p < 2; p++) begin
                pd_in = p[0];
                repeat (3) @(posedge clk);
                #1 chk("chan b down", {9'h0, pd_out}, {9'h0, p[0] & g[0]});
            end
            pd_in = 1'b0;
        end
        rd(mpsc_pkg::OFS_SYNC_TERM, 8'h02);
    endtask : t_gate

    task automatic t_delay;
        logic [4:0] c;
        int         ps;
        for (int k = 0; k < 32; k++) begin
            c  = k[4:0];
            ps = (k >= 8) ? 175 : 175 + (8 - k) * 25;
            wr(mpsc_pkg::OFS_DEL_HIGH, {6'h10, c[4:3]});
            wr(mpsc_pkg::OFS_DEL_LOW, {c[2:0], 5'h00});
            chk("delay code", {5'h00, dcode}, {5'h00, c});
            chk("delay ps", dps, ps[9:0]);
            chk("delay enable", {9'h0, den}, 10'h001);
        end
        wr(mpsc_pkg::OFS_DEL_HIGH, 8'h03);
        chk("delay ps off", dps, 10'h000);
        chk("delay enable", {9'h0, den}, 10'h000);
        chk("delay code", {5'h00, dcode}, 10'h01F);
    endtask : t_delay

    task automatic t_page;
        page_sel = 1'b0;
        wr(mpsc_pkg::OFS_CM_BIAS, 8'h20);
        chk("unselected write", {9'h0, bias}, 10'h000);
        rd(mpsc_pkg::OFS_DEL_HIGH, 8'h00);
        page_sel = 1'b1;
        rd(12'h033, 8'h00);
        wr(mpsc_pkg::OFS_CM_BIAS, 8'h20);
        chk("selected write", {9'h0, bias}, 10'h001);
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        chk("reset clears", {bias, pd_out, term, den, dcode, 1'b0}, 10'h000);
        chk("reset clears ps", dps, 10'h000);
        rd(mpsc_pkg::OFS_CM_BIAS, 8'h00);
        rd(mpsc_pkg::OFS_DEL_HIGH, 8'h00);
    endtask : t_page

    initial begin
        rst_n    = 1'b0;
        page_sel = 1'b1;
        pd_in    = 1'b0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        t_reset();
        t_bias();
        t_gate();
        t_delay();
        t_page();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
